// ### hw/instr_exec_pkg.sv
package instr_exec_pkg;

   // quarter phases of one instruction cycle
   typedef enum logic [1:0] {
      Q_DECODE,
      Q_READ,
      Q_PROCESS,
      Q_WRITE
   } quarter_t;

   // opcode fields of the supported subset
   localparam logic [7:0] OP_CALL_HI = 8'hEC;
   localparam logic [6:0] OP_CALL_HI7 = 7'h76;
   localparam logic [7:0] OP_PTR_LOAD = 8'hEE;
   localparam logic [1:0] PTR_LOAD_SUB = 2'h0;
   localparam logic [5:0] OP_FILE_MOVE = 6'h14;
   localparam logic [6:0] OP_TEST_SKIP = 7'h33;
   localparam logic [7:0] OP_IMM_XOR = 8'h0A;
   localparam logic [3:0] OP_SECOND_WORD = 4'hF;

   // field positions
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam int CALL_SHADOW_BIT = 8;

   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam int NUM_POINTERS = 3;
   localparam int PC_WIDTH = 21;
   localparam int DATA_ADDR_WIDTH = 12;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;

   typedef struct packed {
      logic [DATA_ADDR_WIDTH-1:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } file_req_t;

   typedef struct packed {
      logic n;
      logic z;
   } flags_t;

endpackage : instr_exec_pkg

// ### hw/quarter_phase_gen.sv
`timescale 1ns/1ns
module quarter_phase_gen (
   input wire logic i_core_clk,
   input wire logic i_reset,
   output instr_exec_pkg::quarter_t o_phase,
   output logic o_cycle_end
);
   import instr_exec_pkg::*;

   // four core clocks make one instruction cycle
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_phase <= Q_DECODE;
      end else begin
         case (o_phase)
            Q_DECODE: o_phase <= Q_READ;
            Q_READ: o_phase <= Q_PROCESS;
            Q_PROCESS: o_phase <= Q_WRITE;
            Q_WRITE: o_phase <= Q_DECODE;
            default: o_phase <= Q_DECODE;
         endcase
      end
   end

   assign o_cycle_end = (o_phase == Q_WRITE);

endmodule : quarter_phase_gen

// ### hw/core_instr_subset_exec.sv
// Operation
// - A call pushes the pc, reads both halves of the target and loads the pc, then idles a cycle.
// - The pointer load puts a 12-bit immediate into the pointer named by its 2-bit selector.
// - The pointer load takes two words: high part in cycle one, low byte in cycle two.
// - The file move copies a register to the accumulator or back to itself and sets N and Z.
// - The 8-bit register field reaches any byte of the selected 256-byte bank.
// - Access bit 0 selects the access bank; 1 uses the bank select register.
// - Access bit 0, extended set on and address at most 95 use indexed literal offset mode.
// - The test-skip reads a register and, if zero, discards the next instruction, both words of a two-word one; flags unchanged.
// - The immediate xor combines the accumulator with a byte in one cycle and sets N and Z.
`timescale 1ns/1ns
module core_instr_subset_exec #(
   parameter int PC_W = instr_exec_pkg::PC_WIDTH
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [15:0] i_instr,
   input wire logic i_instr_valid,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic [3:0] i_bank_select_reg,
   input wire logic i_ext_set_en,
   input wire logic [7:0] i_file_rdata,
   output instr_exec_pkg::file_req_t o_file_req,
   output logic [PC_W-1:0] o_pc_load,
   output logic o_pc_load_en,
   output logic [PC_W-1:0] o_return_stack_top,
   output logic o_stack_push,
   output logic o_call_shadow,
   output logic o_fetch_discard,
   output logic [7:0] o_accum,
   output instr_exec_pkg::flags_t o_flags,
   output logic [35:0] o_indirect_pointer,
   output instr_exec_pkg::quarter_t o_phase,
   output logic o_busy
);
   import instr_exec_pkg::*;

   typedef enum {
      ST_EXEC,
      ST_CALL2,
      ST_PTR2,
      ST_SKIP1,
      ST_SKIP2
   } exec_state_t;

   quarter_t phase;
   logic cycle_end;
   exec_state_t state_reg;
   logic [15:0] ir_reg;
   logic [7:0] opnd_reg;
   logic [7:0] result_reg;
   logic [7:0] acc_reg;
   logic [11:0] ptr_reg [NUM_POINTERS];
   logic [1:0] ptr_sel_reg;
   logic [7:0] call_lo_reg;

   quarter_phase_gen u_phase (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .o_phase(phase),
      .o_cycle_end(cycle_end)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic is_two_word(input logic [15:0] w);
      is_two_word = (w[15:9] == OP_CALL_HI7) ||
                    (w[15:8] == OP_PTR_LOAD && w[7:6] == PTR_LOAD_SUB);
   endfunction : is_two_word

   function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank,
                                             input logic ext, input logic [11:0] ptr2);
      logic [11:0] a;
      a = {bank, w[7:0]};
      if (!w[ACCESS_BIT]) begin
         if (ext && w[7:0] <= INDEXED_LIMIT) begin
            a = ptr2 + {4'h0, w[7:0]};
         end else if (w[7:0] < ACCESS_SPLIT) begin
            a = {4'h0, w[7:0]};
         end else begin
            a = {ACCESS_HIGH_BANK, w[7:0]};
         end
      end
      file_addr = a;
   endfunction : file_addr

   wire logic [15:0] cur_w = (phase == Q_DECODE) ? i_instr : ir_reg;
   wire logic op_call = cur_w[15:9] == OP_CALL_HI7;
   wire logic op_ptr = cur_w[15:8] == OP_PTR_LOAD && cur_w[7:6] == PTR_LOAD_SUB;
   wire logic op_move = cur_w[15:10] == OP_FILE_MOVE;
   wire logic op_tst = cur_w[15:9] == OP_TEST_SKIP;
   wire logic op_xor = cur_w[15:8] == OP_IMM_XOR;
   wire logic in_exec = state_reg == ST_EXEC;
   wire logic [7:0] xor_res = acc_reg ^ ir_reg[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // instruction register and multi-cycle sequencing

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ir_reg <= 16'h0000;
      end else if (phase == Q_DECODE && i_instr_valid) begin
         ir_reg <= i_instr;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_reg <= ST_EXEC;
      end else if (cycle_end) begin
         case (state_reg)
            ST_EXEC: begin
               if (op_call) state_reg <= ST_CALL2;
               else if (op_ptr) state_reg <= ST_PTR2;
               else if (op_tst && opnd_reg == 8'h00) state_reg <= ST_SKIP1;
            end
            ST_SKIP1: begin
               // the discarded word is in ir_reg; a two-word one needs one more slot
               state_reg <= is_two_word(ir_reg) ? ST_SKIP2 : ST_EXEC;
            end
            ST_CALL2, ST_PTR2, ST_SKIP2: state_reg <= ST_EXEC;
            default: state_reg <= ST_EXEC;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand read and data processing

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_file_req <= '0;
         opnd_reg <= 8'h00;
      end else begin
         o_file_req.rd <= 1'b0;
         o_file_req.wr <= 1'b0;
         if (in_exec && phase == Q_DECODE && (op_move || op_tst)) begin
            o_file_req.addr <= file_addr(i_instr, i_bank_select_reg, i_ext_set_en,
                                         ptr_reg[2]);
            o_file_req.rd <= 1'b1;
         end
         if (in_exec && phase == Q_READ) begin
            opnd_reg <= (op_move || op_tst) ? i_file_rdata : ir_reg[7:0];
         end
         if (in_exec && phase == Q_PROCESS && op_move && ir_reg[DEST_BIT]) begin
            o_file_req.wr <= 1'b1;
            o_file_req.wdata <= opnd_reg;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         result_reg <= 8'h00;
      end else if (in_exec && phase == Q_PROCESS) begin
         result_reg <= op_xor ? xor_res : opnd_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator and flags, written in the last quarter

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         acc_reg <= ACC_RESET;
         o_flags <= '0;
      end else if (in_exec && phase == Q_WRITE) begin
         if (op_xor || (op_move && !ir_reg[DEST_BIT])) begin
            acc_reg <= result_reg;
         end
         if (op_xor || op_move) begin
            o_flags.n <= result_reg[7];
            o_flags.z <= result_reg == 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pointer registers

   genvar gi;
   generate
      for (gi = 0; gi < NUM_POINTERS; gi++) begin : g_ptr
         always_ff @(posedge i_core_clk) begin
            if (i_reset) begin
               ptr_reg[gi] <= PTR_RESET;
            end else if (phase == Q_WRITE) begin
               if (in_exec && op_ptr && ir_reg[5:4] == 2'(gi)) begin
                  ptr_reg[gi][11:8] <= ir_reg[3:0];
               end
               if (state_reg == ST_PTR2 && ptr_sel_reg == 2'(gi)) begin
                  ptr_reg[gi][7:0] <= ir_reg[7:0];
               end
            end
         end
         assign o_indirect_pointer[gi*12 +: 12] = ptr_reg[gi];
      end
   endgenerate

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         ptr_sel_reg <= 2'h0;
      end else if (in_exec && phase == Q_WRITE && op_ptr) begin
         ptr_sel_reg <= ir_reg[5:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // call: push in process quarter, target in write quarter

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_return_stack_top <= '0;
         o_stack_push <= 1'b0;
         o_pc_load <= '0;
         o_pc_load_en <= 1'b0;
         o_call_shadow <= 1'b0;
         call_lo_reg <= 8'h00;
      end else begin
         o_stack_push <= 1'b0;
         o_pc_load_en <= 1'b0;
         if (in_exec && op_call && phase == Q_READ) begin
            call_lo_reg <= ir_reg[7:0];
         end
         if (in_exec && op_call && phase == Q_PROCESS) begin
            o_return_stack_top <= i_pc;
            o_stack_push <= 1'b1;
            o_call_shadow <= ir_reg[CALL_SHADOW_BIT];
         end
         // second word is on i_instr by the write quarter
         if (in_exec && op_call && phase == Q_WRITE) begin
            o_pc_load <= PC_W'({i_instr[11:0], call_lo_reg, 1'b0});
            o_pc_load_en <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status outputs

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_fetch_discard <= 1'b0;
         o_busy <= 1'b0;
         o_phase <= Q_DECODE;
      end else begin
         o_fetch_discard <= state_reg == ST_SKIP1 || state_reg == ST_SKIP2;
         o_busy <= !in_exec;
         o_phase <= phase;
      end
   end

   assign o_accum = acc_reg;

endmodule : core_instr_subset_exec

// ### test/instr_exec_checker.sv
`timescale 1ns/1ns
module instr_exec_checker #(
   parameter int PC_W = instr_exec_pkg::PC_WIDTH
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire instr_exec_pkg::file_req_t o_file_req,
   input wire logic [PC_W-1:0] o_return_stack_top,
   input wire logic o_pc_load_en,
   input wire logic o_stack_push,
   input wire logic o_fetch_discard,
   input wire logic [7:0] o_accum,
   input wire logic [35:0] o_indirect_pointer,
   input wire instr_exec_pkg::quarter_t o_phase
);
   import instr_exec_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   property p_phase; o_phase != Q_DECODE |=> o_phase == 2'($past(o_phase) + 1); endproperty
   property p_rd; o_file_req.rd |=> !o_file_req.rd; endproperty
   property p_pc; o_pc_load_en |=> !o_pc_load_en [*3]; endproperty
   property p_push; o_stack_push |-> ##[0:4] o_pc_load_en; endproperty
   property p_top; $changed(o_return_stack_top) |-> o_stack_push; endproperty
   property p_dlen; $rose(o_fetch_discard) |-> o_fetch_discard [*4]; endproperty
   property p_dmax; o_fetch_discard [*8] |=> !o_fetch_discard; endproperty
   property p_keep; o_fetch_discard |=> $stable(o_accum) && $stable(o_indirect_pointer); endproperty
   a_phase: assert property (p_phase) else $error("quarter order broken");
   a_rd: assert property (p_rd) else $error("read strobe too long");
   a_pc: assert property (p_pc) else $error("pc load repeated");
   a_push: assert property (p_push) else $error("push without pc load");
   a_top: assert property (p_top) else $error("stack top moved without push");
   a_dlen: assert property (p_dlen) else $error("discard shorter than a cycle");
   a_dmax: assert property (p_dmax) else $error("discard over two cycles");
   a_keep: assert property (p_keep) else $error("discarded word changed state");
   c_call: cover property (o_pc_load_en);
   c_skip: cover property ($rose(o_fetch_discard));
   c_skip2: cover property (o_fetch_discard [*8]);
endmodule : instr_exec_checker

// ### test/reg_file_model.sv
`timescale 1ns/1ns
module reg_file_model (
   input wire logic i_core_clk,
   input wire instr_exec_pkg::file_req_t i_file_req,
   output logic [7:0] o_file_rdata
);
   import instr_exec_pkg::*;
   logic [7:0] mem_reg [4096];
   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem_reg[a] = 8'(a) ^ {2{4'(a >> 8)}};
      end
   end
   // no read strobe: show the inverse so a stale sample never matches
   assign o_file_rdata = i_file_req.rd ? mem_reg[i_file_req.addr] : ~mem_reg[i_file_req.addr];
   always @(posedge i_core_clk) begin
      if (i_file_req.wr) begin
         mem_reg[i_file_req.addr] <= i_file_req.wdata;
      end
   end
endmodule : reg_file_model

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import instr_exec_pkg::*;
   localparam int PC_W = PC_WIDTH;
   logic i_core_clk = 1'b0, i_reset = 1'b1, i_instr_valid = 1'b0, i_ext_set_en = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic [PC_W-1:0] i_pc = '0, o_pc_load, o_return_stack_top, last_pc;
   logic [3:0] i_bank_select_reg = 4'h0;
   logic [7:0] i_file_rdata, o_accum, last_wd, acc;
   file_req_t o_file_req;
   logic o_pc_load_en, o_stack_push, o_call_shadow, o_fetch_discard, o_busy;
   flags_t o_flags, fl;
   logic [35:0] o_indirect_pointer, ptr;
   quarter_t o_phase;
   logic [11:0] last_rd, last_wr;
   logic [11:0] kt [3] = '{12'hFFF, 12'hABC, 12'h100};
   int bad_count = 0, n_checks = 0, n_disc = 0, n_busy = 0, d0;

   core_instr_subset_exec #(.PC_W(PC_W)) u_core_instr_subset_exec (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_instr(i_instr),
      .i_instr_valid(i_instr_valid),
      .i_pc(i_pc),
      .i_bank_select_reg(i_bank_select_reg),
      .i_ext_set_en(i_ext_set_en),
      .i_file_rdata(i_file_rdata),
      .o_file_req(o_file_req),
      .o_pc_load(o_pc_load),
      .o_pc_load_en(o_pc_load_en),
      .o_return_stack_top(o_return_stack_top),
      .o_stack_push(o_stack_push),
      .o_call_shadow(o_call_shadow),
      .o_fetch_discard(o_fetch_discard),
      .o_accum(o_accum),
      .o_flags(o_flags),
      .o_indirect_pointer(o_indirect_pointer),
      .o_phase(o_phase),
      .o_busy(o_busy)
   );
   reg_file_model u_reg_file_model (.i_core_clk(i_core_clk), .i_file_req(o_file_req),
      .o_file_rdata(i_file_rdata));

   initial begin
      forever #25 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      if (o_file_req.rd) last_rd <= o_file_req.addr;
      if (o_file_req.wr) {last_wr, last_wd} <= {o_file_req.addr, o_file_req.wdata};
      if (o_pc_load_en) last_pc <= o_pc_load;
      if (o_fetch_discard) n_disc <= n_disc + 1;
      if (o_busy) n_busy <= n_busy + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // second word must already stand in the write quarter of the first cycle
   task automatic issue(input logic [15:0] w, input logic [15:0] w2 = 16'h0000, input bit two = 0);
      i_instr <= w;
      repeat (3) @(posedge i_core_clk);
      i_instr <= two ? w2 : w;
      repeat (two ? 5 : 1) @(posedge i_core_clk);
   endtask : issue
   task automatic settle;
      issue(16'h0000);
      #1;
   endtask : settle
   task automatic move(input bit a, d, ext, input logic [7:0] f, input logic [11:0] ad);
      logic [7:0] v;
      v = ad[7:0] ^ {2{ad[11:8]}};
      acc = o_accum;
      i_ext_set_en <= ext;
      issue({OP_FILE_MOVE, d, a, f});
      settle();
      chk("read addr", 36'(ad), 36'(last_rd));
      chk("dest", 36'(d ? {ad, v, acc} : {12'h0, 8'h0, v}),
         36'(d ? {last_wr, last_wd, o_accum} : {20'h0, o_accum}));
      chk("flags", 36'({v[7], v == 8'h00}), 36'(o_flags));
   endtask : move
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge i_core_clk);
      #1;
      chk("reset state", 36'h0, {o_indirect_pointer[35:10], o_accum, o_flags});
      i_reset <= 1'b0;
      i_instr_valid <= 1'b1;
      issue({OP_IMM_XOR, 8'h80});
      settle();
      chk("xor set", 36'h202, 36'({o_accum, o_flags}));
      issue({OP_IMM_XOR, 8'h80});
      settle();
      chk("xor clear", 36'h001, 36'({o_accum, o_flags}));
      $display("test xor done");
      for (int s = 0; s < 3; s++) begin
         issue({OP_PTR_LOAD, PTR_LOAD_SUB, 2'(s), kt[s][11:8]},
            {OP_SECOND_WORD, 4'h0, kt[s][7:0]}, 1);
      end
      settle();
      chk("pointers", {12'h100, 12'hABC, 12'hFFF}, o_indirect_pointer);
      $display("test pointer load done");
      i_bank_select_reg <= 4'h3;
      move(1, 0, 0, 8'h45, 12'h345);
      move(0, 0, 0, 8'h70, 12'hF70);
      move(0, 0, 0, 8'h00, 12'h000);
      move(0, 0, 1, 8'h5F, 12'h15F);
      move(0, 1, 1, 8'h60, 12'hF60);
      move(1, 1, 1, 8'hFF, 12'h3FF);
      $display("test file move done");
      i_pc <= 21'h012344;
      issue({OP_CALL_HI7, 1'b1, 8'hDE}, {OP_SECOND_WORD, 12'hABC}, 1);
      settle();
      chk("call", {20'hABCDE, 1'b0, 1'b1}, 36'({last_pc, o_call_shadow}));
      chk("stack top", 36'h012344, 36'(o_return_stack_top));
      $display("test call done");
      // plain access bank so that register 0 really holds zero
      i_ext_set_en <= 1'b0;
      {d0, acc, fl, ptr} = {n_disc, o_accum, o_flags, o_indirect_pointer};
      issue({OP_TEST_SKIP, 1'b0, 8'h00});
      issue({OP_IMM_XOR, 8'hFF});
      settle();
      chk("skip", {acc, fl, 26'(4)}, {o_accum, o_flags, 26'(n_disc - d0)});
      issue({OP_TEST_SKIP, 1'b0, 8'h01});
      issue({OP_IMM_XOR, 8'hFF});
      settle();
      chk("no skip", 36'(acc ^ 8'hFF), 36'(o_accum));
      issue({OP_TEST_SKIP, 1'b0, 8'h00});
      issue({OP_PTR_LOAD, PTR_LOAD_SUB, 2'd0, 4'h1},
         {OP_SECOND_WORD, 4'h0, 8'h23}, 1);
      issue({OP_IMM_XOR, 8'h0F});
      settle();
      chk("long skip", {ptr[27:0], 8'(~acc ^ 8'h0F)}, {o_indirect_pointer[27:0], o_accum});
      chk("long skip span", 36'(12), 36'(n_disc - d0));
      // three pointer loads, one call, one short and one long skip: 7 extra cycles
      chk("busy clocks", 36'(28), 36'(n_busy));
      $display("test skip done");
      give_verdict();
   end
   // about 150 clocks of traffic; twenty times that means a hang
   initial begin
      repeat (3000) @(posedge i_core_clk);
      bad_count++;
      give_verdict();
   end
endmodule : tb_top

bind core_instr_subset_exec instr_exec_checker #(.PC_W(PC_W)) u_instr_exec_checker (
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .o_file_req(o_file_req),
   .o_return_stack_top(o_return_stack_top),
   .o_pc_load_en(o_pc_load_en),
   .o_stack_push(o_stack_push),
   .o_fetch_discard(o_fetch_discard),
   .o_accum(o_accum),
   .o_indirect_pointer(o_indirect_pointer),
   .o_phase(o_phase)
);
